// ==== hdl/disk_regs_pkg.sv ====
// Package with widths, field positions, reset values and serializer counts of the disk controller registers.
package disk_regs_pkg;

   // ****************************************************************
   // Register widths and step sizes
   // ****************************************************************
   localparam int REG_WIDTH = 16;
   localparam logic [15:0] BUS_ADDR_STEP = 16'h0002;
   localparam logic [15:0] ONE_WORD = 16'h0001;
   localparam logic [15:0] ZERO_WORD = 16'h0000;
   localparam logic [1:0] EXT_ZERO = 2'h0;

   // ****************************************************************
   // Control/status field positions
   // ****************************************************************
   localparam int CS_DRDY_BIT = 0;
   localparam int CS_FUNC_LO = 1;
   localparam int CS_FUNC_HI = 3;
   localparam int CS_EXT_LO = 4;
   localparam int CS_EXT_HI = 5;
   localparam int CS_IE_BIT = 6;
   localparam int CS_CONTROLLER_READY_BIT = 7;
   localparam int CS_DSEL_LO = 8;
   localparam int CS_DSEL_HI = 9;
   localparam int CS_OPI_BIT = 10;
   localparam int CS_CRC_BIT = 11;
   localparam int CS_HNF_BIT = 12;
   localparam int CS_NXM_BIT = 13;
   localparam int CS_DERR_BIT = 14;
   localparam int CS_CERR_BIT = 15;

   // ****************************************************************
   // Reset values and serializer counts
   // ****************************************************************
   localparam logic [2:0] FUNC_RESET = 3'h0;
   localparam logic [1:0] DSEL_RESET = 2'h0;
   localparam logic [3:0] SER_FIRST = 4'h0;
   localparam logic [3:0] SER_LAST = 4'hF;

endpackage

// ==== hdl/disk_controller_register_set.sv ====
// Host-visible register set of a disk cartridge controller.
//
// Notes on behaviour
// - Word counter: 16-bit, write-only, negative count.
// - Counter increments per transfer; overflow at zero.
// - Bus address register readable, increments by two.
// - Bus address bit zero always stored zero.
// - Both selects together clear both counters.
// - Write pulse plus own select loads counter.
// - Address enable steps both, drives address.
// - Bus address read needs strobe and select.
// - Two extended address bits via status strobes.
// - Disk address holds sector, seek or status.
// - Disk address loads on pulse and select.
// - Disk address increments after each sector.
// - Disk address serialized through 16:1 multiplexer.
// - Status register: nine control, seven status bits.
// - Status write with bit7 low clears ready.
// - Sync flop blocks status writes and register reads meanwhile.
// - Function bits pick routine; not-ready enables it.
// - Set-ready strobe stops timer, sets ready.
// - Status shows drive on-track and fault.
// - Drive select bits drive drive bus directly.
// - Interrupt enable bit six, software-owned only.
// - Composite error stops DMA, sets ready.
`timescale 1ns/100ps

module disk_controller_register_set
   import disk_regs_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic bus_init,
   input wire logic [15:0] internal_tristate_bus,
   input wire logic register_write_pulse,
   input wire logic word_count_select,
   input wire logic bus_address_select,
   input wire logic bus_address_read,
   input wire logic address_enable,
   input wire logic status_write_select,
   input wire logic status_read_select,
   input wire logic status_write_pulse,
   input wire logic disk_address_write_pulse,
   input wire logic disk_address_write_select,
   input wire logic disk_address_read,
   input wire logic disk_address_increment,
   input wire logic serial_step,
   input wire logic serial_restart,
   input wire logic bus_sync,
   input wire logic set_ready_strobe,
   input wire logic drive_on_track,
   input wire logic drive_fault,
   input wire logic opi_error,
   input wire logic crc_error,
   input wire logic header_mismatch,
   input wire logic nxm_error,
   output logic [15:0] read_data,
   output logic read_data_valid,
   output logic [15:0] dma_address,
   output logic dma_address_valid,
   output logic [1:0] extended_address,
   output logic word_count_overflow,
   output logic [15:0] disk_address_register,
   output logic serial_bit,
   output logic [1:0] disk_address_low,
   output logic controller_ready,
   output logic ready_state_low,
   output logic [2:0] function_code,
   output logic sequencer_run,
   output logic interrupt_enable_bit,
   output logic [1:0] drive_select_bits,
   output logic host_strobe_block,
   output logic opi_start,
   output logic opi_stop,
   output logic dma_inhibit,
   output logic composite_error
);

   // ****************************************************************
   // Reset synchroniser
   // ****************************************************************
   logic rst_meta_reg;
   logic rst_sync_reg;

   // Release of nrst passes through two flops; assertion acts at once.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end

   // Bus initialize clears the block like a reset, but synchronously.
   wire clr = bus_init;

   // ****************************************************************
   // Storage
   // ****************************************************************
   logic [15:0] wc_reg;
   logic [15:0] ba_reg;
   logic [1:0] ext_reg;
   logic [15:0] da_reg;
   logic [2:0] func_reg;
   logic [1:0] dsel_reg;
   logic ie_reg;
   logic drdy_reg;
   logic controller_ready_reg;
   logic sync_reg;
   logic [3:0] ser_cnt_reg;
   logic opi_reg;
   logic crc_reg;
   logic hnf_reg;
   logic nxm_reg;

   // ****************************************************************
   // Word counter and bus address decode
   // ****************************************************************
   wire clear_both = word_count_select && bus_address_select;
   wire wc_load = register_write_pulse && word_count_select && !bus_address_select;
   wire ba_load = register_write_pulse && bus_address_select && !word_count_select;
   // The ripple into the extension counter happens when the low word wraps.
   wire ba_carry = (ba_reg == 16'hFFFE);
   wire [15:0] wc_inc = wc_reg + ONE_WORD;
   wire [15:0] ba_inc = ba_reg + BUS_ADDR_STEP;
   wire [1:0] ext_inc = ext_reg + 2'h1;
   // Composite error is the OR of the four latched error bits and the live drive fault input.
   wire comp_err = opi_reg || crc_reg || hnf_reg || nxm_reg || drive_fault;
   // A transfer step is refused once an error is flagged.
   wire step = address_enable && !comp_err;

   // Word counter: write-only, counts up from the two's complement.
   always_ff @(posedge clk or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         wc_reg <= ZERO_WORD;
      end else if (clr || clear_both) begin
         wc_reg <= ZERO_WORD;
      end else if (wc_load) begin
         wc_reg <= internal_tristate_bus;
      end else if (step) begin
         wc_reg <= wc_inc;
      end
   end

   // Bus address register with a forced-even low bit.
   always_ff @(posedge clk or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         ba_reg <= ZERO_WORD;
      end else if (clr || clear_both) begin
         ba_reg <= ZERO_WORD;
      end else if (ba_load) begin
         ba_reg <= {internal_tristate_bus[15:1], 1'b0};
      end else if (step) begin
         ba_reg <= ba_inc;
      end
   end

   // Extended address bits load with the status word and take the carry.
   wire status_write = status_write_pulse && status_write_select && !sync_reg;
   always_ff @(posedge clk or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         ext_reg <= EXT_ZERO;
      end else if (clr) begin
         ext_reg <= EXT_ZERO;
      end else if (status_write) begin
         ext_reg <= internal_tristate_bus[CS_EXT_HI:CS_EXT_LO];
      end else if (step && ba_carry) begin
         ext_reg <= ext_inc;
      end
   end

   // ****************************************************************
   // Disk address register and serializer
   // ****************************************************************
   wire da_load = disk_address_write_pulse && disk_address_write_select;
   wire [15:0] da_inc = da_reg + ONE_WORD;

   // Holds sector address, seek difference or status request word.
   always_ff @(posedge clk or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         da_reg <= ZERO_WORD;
      end else if (clr) begin
         da_reg <= ZERO_WORD;
      end else if (da_load) begin
         da_reg <= internal_tristate_bus;
      end else if (disk_address_increment) begin
         da_reg <= da_inc;
      end
   end

   // Four-bit binary count walks the 16:1 multiplexer select.
   always_ff @(posedge clk or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         ser_cnt_reg <= SER_FIRST;
      end else if (clr || serial_restart) begin
         ser_cnt_reg <= SER_FIRST;
      end else if (serial_step) begin
         ser_cnt_reg <= ser_cnt_reg + 4'h1;
      end
   end
   wire ser_mux = da_reg[ser_cnt_reg];

   // ****************************************************************
   // Control/status register
   // ****************************************************************
   // Only the write that brings bit 7 low starts a command.
   wire go = status_write && !internal_tristate_bus[CS_CONTROLLER_READY_BIT];
   wire [15:0] csr_word = {comp_err, drive_fault, nxm_reg, hnf_reg, crc_reg, opi_reg,
      dsel_reg, controller_ready_reg, ie_reg, ext_reg, func_reg, drdy_reg};

   // Writable control bits: function, interrupt enable, drive select.
   always_ff @(posedge clk or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         func_reg <= FUNC_RESET;
         dsel_reg <= DSEL_RESET;
         ie_reg <= 1'b0;
      end else if (clr) begin
         func_reg <= FUNC_RESET;
         dsel_reg <= DSEL_RESET;
         ie_reg <= 1'b0;
      end else if (status_write) begin
         func_reg <= internal_tristate_bus[CS_FUNC_HI:CS_FUNC_LO];
         dsel_reg <= internal_tristate_bus[CS_DSEL_HI:CS_DSEL_LO];
         ie_reg <= internal_tristate_bus[CS_IE_BIT];
      end
   end

   // Ready flop and its inverted twin, so both leave a flop; set wins over a same-cycle clear.
   always_ff @(posedge clk or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         controller_ready_reg <= 1'b1;
         ready_state_low <= 1'b0;
      end else if (clr || set_ready_strobe || (comp_err && !controller_ready_reg)) begin
         controller_ready_reg <= 1'b1;
         ready_state_low <= 1'b0;
      end else if (go) begin
         controller_ready_reg <= 1'b0;
         ready_state_low <= 1'b1;
      end
   end

   // Sync flop holds off status writes and register reads while a command runs, so bit 7 stays stable.
   always_ff @(posedge clk or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         sync_reg <= 1'b0;
      end else if (clr || controller_ready_reg) begin
         sync_reg <= 1'b0;
      end else if (bus_sync) begin
         sync_reg <= 1'b1;
      end
   end

   // Error bits are sticky; an incoming error wins over clearing by a new command.
   always_ff @(posedge clk or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         opi_reg <= 1'b0;
         crc_reg <= 1'b0;
         hnf_reg <= 1'b0;
         nxm_reg <= 1'b0;
         drdy_reg <= 1'b0;
      end else begin
         opi_reg <= opi_error || (opi_reg && !clr && !go);
         crc_reg <= crc_error || (crc_reg && !clr && !go);
         hnf_reg <= (opi_error && header_mismatch) || (hnf_reg && !clr && !go);
         nxm_reg <= nxm_error || (nxm_reg && !clr && !go);
         drdy_reg <= drive_on_track;
      end
   end

   // ****************************************************************
   // Read path and registered outputs
   // ****************************************************************
   // Bus address is returned only with both strobes; a latched command blocks reads.
   wire ba_rd = bus_address_read && bus_address_select && !sync_reg;
   wire cs_rd = status_read_select && !sync_reg;
   wire da_rd = disk_address_read && !sync_reg;
   wire [15:0] rd_mux = ba_rd ? ba_reg : (cs_rd ? csr_word : (da_rd ? da_reg : ZERO_WORD));

   always_ff @(posedge clk or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         read_data <= ZERO_WORD;
         read_data_valid <= 1'b0;
         dma_address <= ZERO_WORD;
         dma_address_valid <= 1'b0;
         serial_bit <= 1'b0;
      end else begin
         read_data <= rd_mux;
         read_data_valid <= ba_rd || cs_rd || da_rd;
         dma_address <= step ? ba_reg : ZERO_WORD;
         dma_address_valid <= step;
         serial_bit <= ser_mux;
      end
   end

   // Status flags that the sequencer and drive bus watch, each one flop deep.
   always_ff @(posedge clk or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         opi_start <= 1'b0;
         opi_stop <= 1'b0;
         sequencer_run <= 1'b0;
         composite_error <= 1'b0;
         dma_inhibit <= 1'b0;
         word_count_overflow <= 1'b0;
      end else begin
         opi_start <= go || disk_address_increment;
         opi_stop <= set_ready_strobe;
         sequencer_run <= !controller_ready_reg;
         composite_error <= comp_err;
         dma_inhibit <= comp_err || (wc_reg == ZERO_WORD);
         word_count_overflow <= (wc_reg == ZERO_WORD);
      end
   end

   // Register copies for the remaining outputs.
   assign extended_address = ext_reg;
   assign disk_address_register = da_reg;
   assign disk_address_low = da_reg[1:0];
   assign controller_ready = controller_ready_reg;
   assign function_code = func_reg;
   assign interrupt_enable_bit = ie_reg;
   assign drive_select_bits = dsel_reg;
   assign host_strobe_block = sync_reg;

endmodule

// ==== verification/disk_regs_asserts.sv ====
// Checker for the ports of the disk controller register set.
`timescale 1ns/100ps

module disk_regs_asserts
   import disk_regs_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic bus_init,
   input wire logic [15:0] internal_tristate_bus,
   input wire logic register_write_pulse,
   input wire logic word_count_select,
   input wire logic bus_address_select,
   input wire logic address_enable,
   input wire logic status_write_select,
   input wire logic status_write_pulse,
   input wire logic disk_address_write_pulse,
   input wire logic disk_address_write_select,
   input wire logic disk_address_increment,
   input wire logic serial_step,
   input wire logic serial_restart,
   input wire logic set_ready_strobe,
   input wire logic read_data_valid,
   input wire logic [15:0] dma_address,
   input wire logic dma_address_valid,
   input wire logic word_count_overflow,
   input wire logic [15:0] disk_address_register,
   input wire logic serial_bit,
   input wire logic controller_ready,
   input wire logic [2:0] function_code,
   input wire logic sequencer_run,
   input wire logic interrupt_enable_bit,
   input wire logic [1:0] drive_select_bits,
   input wire logic host_strobe_block,
   input wire logic opi_start,
   input wire logic composite_error
);
   // ********
   // Qualified requests
   // ********
   // Each request is qualified so that a higher-priority clear, load or block never trips a check.
   wire step_ok = address_enable & ~composite_error & ~bus_init & ~word_count_select
      & ~bus_address_select;
   wire wc_zero = register_write_pulse & word_count_select & ~bus_address_select & ~bus_init
      & (internal_tristate_bus == ZERO_WORD);
   wire csr_wr = status_write_select & status_write_pulse & ~host_strobe_block & ~bus_init;
   wire da_inc = disk_address_increment & ~bus_init
      & ~(disk_address_write_pulse & disk_address_write_select);
   wire go = csr_wr & ~internal_tristate_bus[CS_CONTROLLER_READY_BIT] & controller_ready
      & ~set_ready_strobe & ~composite_error;
   wire [5:0] ctl_in = {internal_tristate_bus[9:8], internal_tristate_bus[6],
      internal_tristate_bus[3:1]};

   default clocking dc @(posedge clk); endclocking
   default disable iff (!nrst);

   // ********
   // Properties
   // ********
   AST_BA_STEP: assert property (step_ok ##1 step_ok |=> dma_address_valid
      && dma_address == $past(dma_address) + BUS_ADDR_STEP) else $error("bus address step wrong");
   AST_WC_ZERO: assert property (wc_zero |=> ##1 word_count_overflow)
      else $error("no overflow at zero count");
   AST_DA_INC: assert property (da_inc |=>
      disk_address_register == $past(disk_address_register) + ONE_WORD) else $error("step wrong");
   AST_SERIAL: assert property (serial_restart ##1
      (serial_step && !serial_restart && $stable(disk_address_register)) [*2]
      |=> serial_bit == disk_address_register[1]) else $error("serial bit order wrong");
   AST_GO: assert property (go |=> (!controller_ready && opi_start)
      ##1 sequencer_run) else $error("command start wrong");
   AST_SET_RDY: assert property (set_ready_strobe |=> controller_ready)
      else $error("ready not set");
   AST_CSR: assert property (csr_wr |=>
      {drive_select_bits, interrupt_enable_bit, function_code} == $past(ctl_in))
      else $error("control bits not loaded");
   AST_BLOCK: assert property (host_strobe_block ##1 host_strobe_block
      |-> ##1 !read_data_valid) else $error("read answered while blocked");
endmodule

// ==== verification/host_bus_model.sv ====
// Host processor model: drives the register strobes and collects read data.
`timescale 1ns/100ps

module host_bus_model (
   input wire logic clk,
   input wire logic [15:0] read_data,
   input wire logic read_data_valid,
   output logic [15:0] internal_tristate_bus,
   output logic register_write_pulse,
   output logic word_count_select,
   output logic bus_address_select,
   output logic bus_address_read,
   output logic status_write_select,
   output logic status_read_select,
   output logic status_write_pulse,
   output logic disk_address_write_pulse,
   output logic disk_address_write_select,
   output logic disk_address_read,
   output logic bus_sync
);
   logic [10:0] strobe_reg = 11'h000;
   logic [15:0] rdat;
   logic rok;

   // All strobes come from one vector, so an access changes them in one assignment.
   assign {register_write_pulse, word_count_select, bus_address_select, bus_address_read,
      status_write_select, status_read_select, status_write_pulse, disk_address_write_pulse,
      disk_address_write_select, disk_address_read, bus_sync} = strobe_reg;

   initial internal_tristate_bus = 16'h0000;

   // One access across one rising edge; the released bus shows the inverse, never stale data.
   task automatic acc(input logic [10:0] s, input logic [15:0] d);
      @(negedge clk);
      strobe_reg = s;
      internal_tristate_bus = d;
      @(negedge clk);
      strobe_reg = 11'h000;
      internal_tristate_bus = ~d;
      rok = 1'b0;
      repeat (2) begin
         if (read_data_valid === 1'b1 && !rok) begin
            rok = 1'b1;
            rdat = read_data;
         end
         @(negedge clk);
      end
   endtask
endmodule

// ==== verification/disk_controller_register_set_tb.sv ====
// Self-checking bench for the disk controller register set.
`timescale 1ns/100ps

module disk_controller_register_set_tb
   import disk_regs_pkg::*;
;
   logic clk, nrst, bus_init, address_enable, disk_address_increment, serial_step;
   logic serial_restart, set_ready_strobe, drive_on_track, drive_fault, opi_error;
   logic crc_error, header_mismatch, nxm_error, register_write_pulse, word_count_select;
   logic bus_address_select, bus_address_read, status_write_select, status_read_select;
   logic status_write_pulse, disk_address_write_pulse, disk_address_write_select;
   logic disk_address_read, bus_sync, read_data_valid, dma_address_valid, word_count_overflow;
   logic serial_bit, controller_ready, ready_state_low, sequencer_run, interrupt_enable_bit;
   logic host_strobe_block, opi_start, opi_stop, dma_inhibit, composite_error;
   logic [15:0] internal_tristate_bus, read_data, dma_address, disk_address_register, d, ba;
   logic [1:0] extended_address, disk_address_low, drive_select_bits;
   logic [2:0] function_code;
   int num_errors = 0, compares = 0, cycles = 0, i, n;
   integer seed = 32'h0000_0d66;

   disk_controller_register_set dut_u (.*);
   host_bus_model host_u (.*);

   // Free-running 100 MHz clock.
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Hang guard; the sequence needs well under a thousand cycles.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         num_errors++;
         test_done();
      end
   end

   function automatic logic [15:0] even_addr(input logic [15:0] v);
      return v & 16'hFFFE;
   endfunction

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      compares++;
      if (g !== e) begin
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
         num_errors++;
      end
   endtask

   task automatic test_done();
      if (num_errors == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Main sequence; every input changes on the falling edge.
   initial begin
      {nrst, bus_init, address_enable, disk_address_increment, serial_step} = 5'h00;
      {serial_restart, set_ready_strobe, drive_on_track, drive_fault, nxm_error} = 5'h00;
      {opi_error, crc_error, header_mismatch} = 3'h0;
      repeat (6) @(negedge clk);
      nrst = 1'b1;
      repeat (3) @(negedge clk);
      chk("ready_reset", 1, controller_ready);
      // Counters: random loads, back-to-back steps, wrap at the top, overflow at zero.
      for (i = 0; i < 4; i++) begin
         ba = (i == 0) ? 16'hFFFF : $random(seed);
         n = 1 + ($random(seed) & 7);
         host_u.acc(11'h500, ba);
         host_u.acc(11'h600, 16'(-n));
         host_u.acc(11'h180, 16'h0000);
         chk("bus_address", even_addr(ba), host_u.rdat);
         chk("overflow_inhibit", 0, {word_count_overflow, dma_inhibit});
         address_enable = 1'b1;
         for (int j = 0; j < n; j++) begin
            @(negedge clk);
            chk("dma_address", even_addr(ba) + 16'(2 * j), dma_address);
         end
         address_enable = 1'b0;
         repeat (2) @(negedge clk);
         chk("overflow_inhibit", 3, {word_count_overflow, dma_inhibit});
         if (i == 0) chk("ext_address", 1, extended_address);
      end
      // A zero load overflows at once; both selects together clear both counters.
      host_u.acc(11'h600, 16'h8000);
      chk("overflow", 0, word_count_overflow);
      host_u.acc(11'h600, 16'h0000);
      chk("overflow", 1, word_count_overflow);
      host_u.acc(11'h600, 16'h8000);
      host_u.acc(11'h300, 16'h1234);
      host_u.acc(11'h180, 16'h0000);
      chk("bus_address", 0, host_u.rdat);
      chk("overflow", 1, word_count_overflow);
      host_u.acc(11'h080, 16'h0000);
      chk("read_valid", 0, host_u.rok);
      // Disk address: load, read back, increment with wrap, then a full serial walk.
      for (i = 0; i < 3; i++) begin
         d = (i == 0) ? 16'hFFFF : $random(seed);
         host_u.acc(11'h00C, d);
         host_u.acc(11'h002, 16'h0000);
         chk("disk_address", d, host_u.rdat);
         chk("disk_address_low", d[1:0], disk_address_low);
         disk_address_increment = 1'b1;
         @(negedge clk);
         disk_address_increment = 1'b0;
         @(negedge clk);
         chk("disk_address", d + ONE_WORD, disk_address_register);
      end
      ba = d + ONE_WORD;
      serial_restart = 1'b1;
      @(negedge clk);
      serial_restart = 1'b0;
      // Sixteen steps show every multiplexer input once, bit 0 first.
      for (i = 0; i < 16; i++) begin
         serial_step = 1'b1;
         @(negedge clk);
         chk("serial_bit", ba[i], serial_bit);
      end
      serial_step = 1'b0;
      // Every function code, with random control bits and ready written either way.
      for (i = 0; i < 8; i++) begin
         d = $random(seed);
         d[3:1] = i[2:0];
         host_u.acc(11'h050, d);
         chk("controls", {d[9:8], d[6], d[3:1]},
            {drive_select_bits, interrupt_enable_bit, function_code});
         chk("ready_run", {d[7], !d[7], !d[7]},
            {controller_ready, sequencer_run, ready_state_low});
         set_ready_strobe = 1'b1;
         @(negedge clk);
         set_ready_strobe = 1'b0;
         chk("opi_stop", 1, opi_stop);
         @(negedge clk);
         chk("ready_stop", 2, {controller_ready, opi_stop});
      end
      host_u.acc(11'h020, 16'h0000);
      chk("status", {6'h00, d[9:8], 1'b1, d[6:1], 1'b0}, host_u.rdat);
      chk("ext_address", d[5:4], extended_address);
      // Every error source during a command is reported, forces ready and refuses DMA steps.
      drive_on_track = 1'b1;
      host_u.acc(11'h050, 16'h0000);
      {drive_fault, nxm_error, opi_error, crc_error, header_mismatch} = 5'h1F;
      @(negedge clk);
      {nxm_error, opi_error, crc_error, header_mismatch} = 4'h0;
      repeat (3) @(negedge clk);
      chk("ready", 1, controller_ready);
      address_enable = 1'b1;
      @(negedge clk);
      address_enable = 1'b0;
      chk("dma_valid", 0, dma_address_valid);
      host_u.acc(11'h020, 16'h0000);
      chk("status", 16'hFC81, host_u.rdat & 16'hFC81);
      {drive_fault, bus_init} = 2'h1;
      @(negedge clk);
      bus_init = 1'b0;
      repeat (2) @(negedge clk);
      chk("composite", 0, composite_error);
      // Status reads are shut out while a command runs, and let in again once ready.
      host_u.acc(11'h050, 16'h0000);
      host_u.acc(11'h001, 16'h0000);
      chk("block", 1, host_strobe_block);
      host_u.acc(11'h020, 16'h0000);
      chk("read_valid", 0, host_u.rok);
      set_ready_strobe = 1'b1;
      @(negedge clk);
      set_ready_strobe = 1'b0;
      host_u.acc(11'h020, 16'h0000);
      chk("ready_bit", {1'b1, 1'b1}, {host_u.rok, host_u.rdat[7]});
      test_done();
   end
endmodule

bind disk_controller_register_set disk_regs_asserts chk_u (.*);
